// ===== core/fp_mac_parallel_and_max_exec.sv
// Float multiply-add, multiply-accumulate with load and maximum execution over AHB-Lite
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`include "fp_exec_cfg.svh"

module fp_mac_parallel_and_max_exec (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire fp_exec_pkg::word_type hwdata,
  input  wire logic                  hready,
  output fp_exec_pkg::word_type      hrdata,
  output logic                       hreadyout,
  output logic                       hresp
);
  import fp_exec_pkg::*;

  // Returns {overflow, underflow, result}; denormal inputs count as zero, truncating
  function automatic logic [33:0] fmul(input word_type x, input word_type y);
    logic              s;
    logic signed [9:0] e;
    logic [47:0]       p;
    logic [22:0]       m;
    s = x[31] ^ y[31];
    e = $signed({2'b00, x[30:23]}) + $signed({2'b00, y[30:23]}) - `EXP_BIAS;
    p = {1'b1, x[22:0]} * {1'b1, y[22:0]};
    m = p[45:23];
    if (p[47]) begin
      m = p[46:24];
      e = e + 10'sd1;
    end
    if (x[30:23] == 8'h00 || y[30:23] == 8'h00) begin
      fmul = {2'b00, s, 31'h0};
    end else if (e >= `EXP_MAX) begin
      fmul = {2'b10, s, 8'hFF, 23'h0};
    end else if (e <= 10'sd0) begin
      fmul = {2'b01, s, 31'h0};
    end else begin
      fmul = {2'b00, s, e[7:0], m};
    end
  endfunction

  function automatic logic [33:0] fadd(input word_type x, input word_type y);
    word_type          a;
    word_type          b;
    logic signed [9:0] e;
    logic [26:0]       ma;
    logic [26:0]       mb;
    logic [26:0]       s;
    logic [7:0]        d;
    integer            i;
    a = x;
    b = y;
    if (x[30:0] < y[30:0]) begin
      a = y;
      b = x;
    end
    e = $signed({2'b00, a[30:23]});
    d = a[30:23] - b[30:23];
    ma = (a[30:23] == 8'h00) ? 27'h0 : {2'b01, a[22:0], 2'b00};
    mb = (b[30:23] == 8'h00) ? 27'h0 : ({2'b01, b[22:0], 2'b00} >> d);
    s = (a[31] == b[31]) ? ma + mb : ma - mb;
    if (s[26]) begin
      s = {1'b0, s[26:1]};
      e = e + 10'sd1;
    end
    for (i = 0; i < 26; i++) begin
      if (!s[25] && s != 27'h0) begin
        s = {s[25:0], 1'b0};
        e = e - 10'sd1;
      end
    end
    if (s == 27'h0 || a[30:23] == 8'h00) begin
      fadd = {2'b00, (s == 27'h0) ? 1'b0 : a[31], 31'h0};
    end else if (e >= `EXP_MAX) begin
      fadd = {2'b10, a[31], 8'hFF, 23'h0};
    end else if (e <= 10'sd0) begin
      fadd = {2'b01, a[31], 31'h0};
    end else begin
      fadd = {2'b00, a[31], e[7:0], s[24:2]};
    end
  endfunction

  // Sign-magnitude word mapped so that plain unsigned order equals float order
  function automatic word_type order_key(input word_type v);
    order_key = v[31] ? ~v : {1'b1, v[30:0]};
  endfunction

  function automatic word_type max_fix(input word_type v);
    max_fix = v;
    if (v[30:23] == 8'hFF && v[22:0] != 23'h0) begin
      max_fix = {v[31], 8'hFF, 23'h0};
    end else if (v[30:23] == 8'h00 && v[22:0] != 23'h0) begin
      max_fix = 32'h0000_0000;
    end
  endfunction

  // Bus side state
  logic        dp_wr_q;
  logic        dp_rd_q;
  logic [7:0]  dp_addr_q;
  word_type    hrdata_q;
  logic        hreadyout_q;
  logic        hresp_q;
  // Programmer-visible state
  logic [15:0] instr_lo_q;
  logic [15:0] instr_hi_q;
  word_type    mem_word_q;
  word_type    freg_q [`FREG_COUNT];
  logic [9:0]  status_q;
  // Two-cycle pipe for the multiply and the accumulate add
  logic        pv_q;
  sel_type     pm_dst_q;
  word_type    pm_res_q;
  word_type    pa_res_q;
  logic        p_ovf_q;
  logic        p_unf_q;

  logic        addr_ok;
  logic        issue;
  logic        sw_freg_we;
  op_type      op;
  sel_type     sel_a;
  sel_type     sel_b;
  sel_type     sel_d;
  sel_type     sel_e;
  sel_type     sel_f;
  word_type    imm_word;
  word_type    max_src;
  word_type    max_res;
  logic        max_lt;
  logic        max_eq;
  logic [33:0] mul_out;
  logic [33:0] add_out;
  logic        max_we;
  logic        load_we;
  logic        pair_go;

  assign addr_ok = hsel && htrans[1] && hready;
  assign issue = dp_wr_q && dp_addr_q == `OFS_ISSUE;
  assign sw_freg_we = dp_wr_q && dp_addr_q[7:5] == 3'(`OFS_FREG_BASE >> 5);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_wr_q <= 1'b0;
      dp_rd_q <= 1'b0;
      dp_addr_q <= 8'h00;
    end else begin
      dp_wr_q <= addr_ok && hwrite;
      dp_rd_q <= addr_ok && !hwrite;
      if (addr_ok) begin
        dp_addr_q <= {haddr[7:2], 2'b00};
      end
    end
  end

  // Reads take one wait state so that a read right after a write sees the new value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      hreadyout_q <= !(addr_ok && !hwrite);
      hresp_q <= 1'b0;
      if (dp_rd_q) begin
        if (dp_addr_q[7:5] == 3'(`OFS_FREG_BASE >> 5)) begin
          hrdata_q <= freg_q[dp_addr_q[4:2]];
        end else begin
          case (dp_addr_q)
            `OFS_INSTR_LO: hrdata_q <= {16'h0000, instr_lo_q};
            `OFS_INSTR_HI: hrdata_q <= {16'h0000, instr_hi_q};
            `OFS_MEM_WORD: hrdata_q <= mem_word_q;
            `OFS_STATUS:   hrdata_q <= {22'h0, status_q[9:8] | {1'b0, pv_q}, status_q[7:0]};
            default:       hrdata_q <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_lo_q <= 16'h0000;
      instr_hi_q <= 16'h0000;
      mem_word_q <= 32'h0000_0000;
    end else if (dp_wr_q) begin
      if (dp_addr_q == `OFS_INSTR_LO) begin
        instr_lo_q <= hwdata[15:0];
      end
      if (dp_addr_q == `OFS_INSTR_HI) begin
        instr_hi_q <= hwdata[15:0];
      end
      if (dp_addr_q == `OFS_MEM_WORD) begin
        mem_word_q <= hwdata;
      end
    end
  end

  // Decode of the instruction words
  always_comb begin
    op = OP_BAD;
    sel_a = instr_hi_q[2:0];
    sel_b = instr_hi_q[5:3];
    sel_d = instr_hi_q[8:6];
    sel_e = 3'h0;
    sel_f = 3'h0;
    imm_word = {instr_lo_q[2:0], instr_hi_q[15:3], 16'h0000};
    if (instr_lo_q == `OP_MAXR_LO && instr_hi_q[15:6] == 10'h000) begin
      op = OP_MAXR;
    end else if (instr_lo_q[15:3] == `OP_MAXI_PFX) begin
      op = OP_MAXI;
    end else if (instr_lo_q[15:4] == `OP_MACMV_PFX) begin
      op = OP_MACMV;
      sel_f = {instr_lo_q[3:2], instr_lo_q[0]};
      sel_e = {instr_lo_q[1], instr_hi_q[15:14]};
      sel_d = instr_hi_q[13:11];
      sel_a = instr_hi_q[10:8];
    end else if (instr_lo_q[15:4] == `OP_PMA_PFX) begin
      op = OP_PMA;
      sel_e = instr_hi_q[5:3];
      sel_f = instr_hi_q[2:0];
    end
  end

  assign max_src = (op == OP_MAXI) ? imm_word : freg_q[sel_b];
  assign max_lt = order_key(freg_q[sel_a]) < order_key(max_src);
  assign max_eq = freg_q[sel_a] == max_src;
  assign max_res = max_fix(max_lt ? max_src : freg_q[sel_a]);
  assign mul_out = fmul(freg_q[sel_e], freg_q[sel_f]);
  assign add_out = fadd(freg_q[7], freg_q[6]);
  assign max_we = issue && (op == OP_MAXR || op == OP_MAXI);
  assign load_we = issue && op == OP_MACMV;
  assign pair_go = issue && (op == OP_MACMV || op == OP_PMA);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pv_q <= 1'b0;
      pm_dst_q <= 3'h0;
      pm_res_q <= 32'h0000_0000;
      pa_res_q <= 32'h0000_0000;
      p_ovf_q <= 1'b0;
      p_unf_q <= 1'b0;
    end else begin
      pv_q <= pair_go;
      if (pair_go) begin
        pm_dst_q <= sel_d;
        pm_res_q <= mul_out[31:0];
        pa_res_q <= add_out[31:0];
        p_ovf_q <= mul_out[33] | add_out[33];
        p_unf_q <= mul_out[32] | add_out[32];
      end
    end
  end

  // one writer per float register, newest instruction wins
  for (genvar g = 0; g < `FREG_COUNT; g++) begin : g_freg
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        freg_q[g] <= `FREG_RESET;
      end else if (load_we && sel_a == g) begin
        freg_q[g] <= mem_word_q;
      end else if (max_we && sel_a == g) begin
        freg_q[g] <= max_res;
      end else if (pv_q && g == 7) begin
        freg_q[g] <= pa_res_q;
      end else if (pv_q && pm_dst_q == g) begin
        freg_q[g] <= pm_res_q;
      end else if (sw_freg_we && dp_addr_q[4:2] == g) begin
        freg_q[g] <= hwdata;
      end
    end
  end

  // Status: a hardware set in the same cycle as a software write still wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= `STATUS_RESET;
    end else begin
      if (dp_wr_q && dp_addr_q == `OFS_STATUS) begin
        status_q <= hwdata[9:0];
      end
      if (issue && op == OP_BAD) begin
        status_q[`ST_ILLEGAL] <= 1'b1;
      end
      if (pv_q && p_unf_q) begin
        status_q[`ST_LUF] <= 1'b1;
      end
      if (pv_q && p_ovf_q) begin
        status_q[`ST_LVF] <= 1'b1;
      end
      if (max_we) begin
        status_q[`ST_ZF] <= max_eq;
        status_q[`ST_NF] <= max_lt;
      end
      if (load_we) begin
        status_q[`ST_ZF] <= mem_word_q[30:23] == 8'h00;
        status_q[`ST_NF] <= mem_word_q[31] && mem_word_q[30:23] != 8'h00;
        status_q[`ST_ZI] <= mem_word_q == 32'h0000_0000;
        status_q[`ST_NI] <= mem_word_q[31];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_pair_late;
    pair_go |-> ##2 freg_q[7] == $past(add_out[31:0], 2);
  endproperty
  a_pair_late: assert property (p_pair_late) else $error("accumulate not in R7 after slot");

  property p_pair_not_early;
    pair_go && add_out[31:0] != freg_q[7] && !load_we |=> freg_q[7] == $past(freg_q[7]);
  endproperty
  a_pair_not_early: assert property (p_pair_not_early) else $error("R7 changed too early");

  property p_load_now;
    load_we |=> freg_q[$past(sel_a)] == $past(mem_word_q);
  endproperty
  a_load_now: assert property (p_load_now) else $error("load word not in place");

  property p_load_fflags;
    load_we |=> status_q[`ST_ZF] == ($past(mem_word_q[30:23]) == 8'h00)
      && (status_q[`ST_NF] == ($past(mem_word_q[31]) && !status_q[`ST_ZF]));
  endproperty
  a_load_fflags: assert property (p_load_fflags) else $error("float flags wrong on load");

  property p_load_iflags;
    load_we |=> status_q[`ST_ZI] == ($past(mem_word_q) == 32'h0)
      && status_q[`ST_NI] == $past(mem_word_q[31]);
  endproperty
  a_load_iflags: assert property (p_load_iflags) else $error("integer flags wrong on load");

  property p_pma_quiet;
    issue && op == OP_PMA |=> $stable(status_q[6:2]) ##1 $stable(status_q[6:2]);
  endproperty
  a_pma_quiet: assert property (p_pma_quiet) else $error("pair touched test or zero flags");

  property p_ovf_latch;
    pv_q && p_ovf_q |=> status_q[`ST_LVF];
  endproperty
  a_ovf_latch: assert property (p_ovf_latch) else $error("overflow not latched");

  property p_unf_latch;
    pv_q && p_unf_q |=> status_q[`ST_LUF];
  endproperty
  a_unf_latch: assert property (p_unf_latch) else $error("underflow not latched");

  property p_max_flags;
    max_we |=> status_q[`ST_ZF] == $past(max_eq) && status_q[`ST_NF] == $past(max_lt)
      && !(status_q[`ST_ZF] && status_q[`ST_NF]);
  endproperty
  a_max_flags: assert property (p_max_flags) else $error("maximum flags wrong");

  property p_max_keep;
    max_we && !max_lt && max_fix(freg_q[sel_a]) == freg_q[sel_a]
      |=> freg_q[$past(sel_a)] == $past(freg_q[sel_a]);
  endproperty
  a_max_keep: assert property (p_max_keep) else $error("maximum changed larger register");

  property p_max_clean;
    max_we |=> freg_q[$past(sel_a)][30:23] != 8'h00 && freg_q[$past(sel_a)][30:23] != 8'hFF
      || freg_q[$past(sel_a)][22:0] == 23'h0;
  endproperty
  a_max_clean: assert property (p_max_clean) else $error("NaN or denormal stored");
endmodule

// ===== core/fp_exec_cfg.svh
// Offsets, field positions, opcodes, reset values and counts of the float execution block
`ifndef FP_EXEC_CFG_SVH
`define FP_EXEC_CFG_SVH

`define OFS_INSTR_LO   8'h00
`define OFS_INSTR_HI   8'h04
`define OFS_MEM_WORD   8'h08
`define OFS_ISSUE      8'h0C
`define OFS_STATUS     8'h10
`define OFS_FREG_BASE  8'h20

`define OP_MAXR_LO     16'hE696
`define OP_MAXI_PFX    13'h1D04
`define OP_MACMV_PFX   12'hE3C
`define OP_PMA_PFX     12'hE74

`define ST_LVF         0
`define ST_LUF         1
`define ST_NF          2
`define ST_ZF          3
`define ST_NI          4
`define ST_ZI          5
`define ST_TF          6
`define ST_BUSY        8
`define ST_ILLEGAL     9

`define FREG_RESET     32'h0000_0000
`define STATUS_RESET   10'h000
`define EXP_BIAS       10'sd127
`define EXP_MAX        10'sd255
`define FREG_COUNT     8

`endif

// ===== core/fp_exec_pkg.sv
// Types shared by the float execution block
package fp_exec_pkg;
  typedef logic [31:0] word_type;
  typedef logic [2:0]  sel_type;
  // Decoded operation, Gray coded along the usual decode order
  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_MAXR  = 3'b001,
    OP_MAXI  = 3'b011,
    OP_MACMV = 3'b010,
    OP_PMA   = 3'b110,
    OP_BAD   = 3'b111
  } op_type;
endpackage

// ===== testbench/host_bus_master.sv
// Bus master model standing in for the host pipeline that feeds the execution block
module host_bus_master (
  input  wire logic                  clk,
  input  wire logic                  hready,
  input  wire fp_exec_pkg::word_type hrdata,
  output logic                       hsel,
  output logic [31:0]                haddr,
  output logic [1:0]                 htrans,
  output logic                       hwrite,
  output logic [2:0]                 hsize,
  output fp_exec_pkg::word_type      hwdata
);
  timeunit 1ns;
  timeprecision 100ps;
  import fp_exec_pkg::*;

  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // No cycle count is assumed; the bench watchdog bounds a stuck slave
  task automatic wait_ready();
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
  endtask

  task automatic write_word(input logic [31:0] a, input word_type d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= 1'b1;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    // Released data lines must not look like held data
    hwdata <= ~d;
  endtask

  task automatic read_word(input logic [31:0] a, output word_type d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= 1'b0;
    wait_ready();
    htrans <= 2'b00;
    wait_ready();
    d = hrdata;
  endtask
endmodule

// ===== testbench/fp_mac_parallel_and_max_exec_tb.sv
// Self-checking bench: register access, execution results and flags of the float block
`include "fp_exec_cfg.svh"

module fp_mac_parallel_and_max_exec_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import fp_exec_pkg::*;

  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  word_type    hwdata;
  word_type    hrdata;
  logic        hreadyout;
  logic        hresp;
  int          miscompares;
  int          check_count;

  host_bus_master u_host (
    .clk    (clk),
    .hready (hreadyout),
    .hrdata (hrdata),
    .hsel   (hsel),
    .haddr  (haddr),
    .htrans (htrans),
    .hwrite (hwrite),
    .hsize  (hsize),
    .hwdata (hwdata)
  );

  fp_mac_parallel_and_max_exec u_dut (
    .clk       (clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  function automatic logic [7:0] freg(input int n);
    return `OFS_FREG_BASE + 8'(4 * n);
  endfunction

  task automatic check(input word_type got, input word_type exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input word_type d);
    u_host.write_word({24'h00_0000, a}, d);
  endtask

  task automatic rd_check(input logic [7:0] a, input word_type exp);
    word_type v;
    u_host.read_word({24'h00_0000, a}, v);
    check(v, exp);
    check({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask

  task automatic issue(input logic [15:0] lo, input logic [15:0] hi, input word_type mem);
    wr(`OFS_INSTR_LO, {16'h0000, lo});
    wr(`OFS_INSTR_HI, {16'h0000, hi});
    wr(`OFS_MEM_WORD, mem);
    wr(`OFS_ISSUE, 32'h0000_0001);
  endtask

  // Flag bits other than zero and negative stay at the pattern written beforehand
  task automatic max_case(input logic imm, input sel_type a, input sel_type b,
                          input word_type va, input word_type vb, input word_type exp,
                          input logic [1:0] zn);
    wr(freg(a), va);
    if (imm) begin
      issue({13'h1D04, vb[31:29]}, {vb[28:16], a}, 32'h0000_0000);
    end else begin
      wr(freg(b), vb);
      issue(16'hE696, {10'h000, b, a}, 32'h0000_0000);
    end
    rd_check(freg(a), exp);
    rd_check(`OFS_STATUS, {24'h00_0000, 4'h7, zn, 2'b11});
  endtask

  task automatic mac_case(input word_type mem, r7, r6, sum, input logic [5:0] flags);
    wr(`OFS_STATUS, 32'h0000_0000);
    wr(freg(7), r7);
    wr(freg(6), r6);
    // load into R4, product into R3
    issue(16'hE3C1, 16'h1C00, mem);
    rd_check(freg(4), mem);
    rd_check(freg(3), 32'h40C0_0000);
    rd_check(freg(7), sum);
    rd_check(`OFS_STATUS, {26'h000_0000, flags});
  endtask

  task automatic pair_case(input word_type r0, r1, r7, r6, prod, sum, input logic [1:0] flags);
    wr(`OFS_STATUS, 32'h0000_007C);
    wr(freg(0), r0);
    wr(freg(1), r1);
    wr(freg(7), r7);
    wr(freg(6), r6);
    // product goes to R2, never R7
    issue({`OP_PMA_PFX, 4'h0}, 16'h0081, 32'h0000_0000);
    // delay slot touches neither R2 nor R7
    wr(`OFS_MEM_WORD, 32'h0000_0000);
    rd_check(freg(2), prod);
    rd_check(freg(7), sum);
    rd_check(`OFS_STATUS, {24'h00_0000, 6'h1F, flags});
  endtask

  task automatic results();
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int n = 0; n < 8; n++) rd_check(freg(n), 32'h0000_0000);
    rd_check(`OFS_STATUS, 32'h0000_0000);
    wr(8'h14, 32'h1234_5678);
    rd_check(8'h14, 32'h0000_0000);
    wr(`OFS_INSTR_LO, 32'hFFFF_E696);
    rd_check(`OFS_INSTR_LO, 32'h0000_E696);
    wr(`OFS_STATUS, 32'h0000_0073);
    max_case(1'b0, 3'd5, 3'd6, 32'h40A0_0000, 32'hC000_0000, 32'h40A0_0000, 2'b00);
    max_case(1'b0, 3'd5, 3'd6, 32'hC000_0000, 32'hBFC0_0000, 32'hBFC0_0000, 2'b01);
    max_case(1'b0, 3'd0, 3'd7, 32'h4000_0000, 32'h4000_0000, 32'h4000_0000, 2'b10);
    max_case(1'b0, 3'd7, 3'd0, 32'h3F80_0000, 32'h7FC0_0000, 32'h7F80_0000, 2'b01);
    max_case(1'b0, 3'd5, 3'd6, 32'hBF80_0000, 32'h0000_0001, 32'h0000_0000, 2'b01);
    max_case(1'b1, 3'd3, 3'd0, 32'h40A0_0000, 32'h40B0_0000, 32'h40B0_0000, 2'b01);
    max_case(1'b1, 3'd7, 3'd0, 32'h4080_0000, 32'h4020_0000, 32'h4080_0000, 2'b00);
    max_case(1'b1, 3'd2, 3'd0, 32'hBFC0_0000, 32'hBF80_0000, 32'hBF80_0000, 2'b01);
    max_case(1'b1, 3'd2, 3'd0, 32'hBFC0_0000, 32'hBFC0_0000, 32'hBFC0_0000, 2'b10);
    wr(freg(0), 32'h4000_0000);
    wr(freg(1), 32'h4040_0000);
    mac_case(32'h8000_0000, 32'h3F80_0000, 32'h0, 32'h3F80_0000, 6'h18);
    mac_case(32'h0000_0000, 32'h3F80_0000, 32'h0, 32'h3F80_0000, 6'h28);
    mac_case(32'hC000_0000, 32'h3F80_0000, 32'h0, 32'h3F80_0000, 6'h14);
    mac_case(32'h3F80_0000, 32'h7F00_0000, 32'h7F00_0000, 32'h7F80_0000, 6'h01);
    pair_case(32'h4000_0000, 32'h4040_0000, 32'h3F80_0000, 32'h3F00_0000,
              32'h40C0_0000, 32'h3FC0_0000, 2'b00);
    pair_case(32'h4000_0000, 32'h4040_0000, 32'h7F00_0000, 32'h7F00_0000,
              32'h40C0_0000, 32'h7F80_0000, 2'b01);
    pair_case(32'h0080_0000, 32'h3F00_0000, 32'h3F80_0000, 32'h3F00_0000,
              32'h0000_0000, 32'h3FC0_0000, 2'b10);
    wr(`OFS_STATUS, 32'h0000_0000);
    wr(freg(5), 32'h1111_1111);
    issue(16'hE696, 16'h0435, 32'h0000_0000);
    rd_check(freg(5), 32'h1111_1111);
    rd_check(`OFS_STATUS, 32'h0000_0200);
    results();
  end

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule
